// ===== hw/crc_check_pkg.sv
package crc_check_pkg;
    localparam int          SIG_W          = 32;
    localparam int          WORD_W         = 16;
    localparam int          LEN_W          = 16;
    localparam logic [31:0] SIG_RST        = 32'hFFFFFFFF;
    localparam logic [31:0] POLY_RST       = 32'h04C11DB7;
    localparam logic [31:0] EXPECT_RST     = 32'h00000000;
    localparam logic [15:0] LEN_RST        = 16'h0001;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} chk_state_t;
endpackage : crc_check_pkg

// ===== hw/sig_compare.sv
`timescale 1ns/100ps
// independent compare path: its own registered copy of the expected value
module sig_compare
    import crc_check_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic              load_expect,
    input  wire logic [SIG_W-1:0]  expect_in,
    input  wire logic              check,
    input  wire logic [SIG_W-1:0]  sig_in,
    output logic                   mismatch
);
    logic [SIG_W-1:0] expect_q;
    logic [SIG_W-1:0] next_expect_q;
    logic             next_mismatch;

    always_comb begin
        next_expect_q = expect_q;
        next_mismatch = mismatch;
        if (load_expect) begin
            next_expect_q = expect_in;
        end
        if (check) begin
            next_mismatch = (sig_in != expect_q);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            expect_q <= EXPECT_RST;
            mismatch <= 1'b0;
        end else if (clk_en) begin
            expect_q <= next_expect_q;
            mismatch <= next_mismatch;
        end
    end
endmodule : sig_compare

// ===== hw/memory_crc_checker.sv
`timescale 1ns/100ps
module memory_crc_checker
    import crc_check_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic [SIG_W-1:0]  poly,
    input  wire logic [SIG_W-1:0]  seed,
    input  wire logic [LEN_W-1:0]  block_len,
    input  wire logic [SIG_W-1:0]  expect_sig,
    input  wire logic              start,
    input  wire logic              prng_step,
    input  wire logic              word_valid,
    output logic                   word_ready,
    input  wire logic [WORD_W-1:0] word_data,
    output logic [SIG_W-1:0]       signature,
    output logic                   block_done,
    output logic                   crc_error,
    output logic                   crc_irq,
    input  wire logic              irq_clear,
    output logic                   busy
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [SIG_W-1:0] crc_fold(input logic [SIG_W-1:0] s,
                                                  input logic [WORD_W-1:0] d,
                                                  input logic [SIG_W-1:0] p);
        logic [SIG_W-1:0] r;
        logic             fb;
        r = s;
        // msb first, sixteen shifts unrolled in one cycle
        for (int i = WORD_W - 1; i >= 0; i--) begin
            fb = r[SIG_W-1] ^ d[i];
            r  = {r[SIG_W-2:0], 1'b0} ^ (fb ? p : '0);
        end
        return r;
    endfunction : crc_fold

    ////////////////////////////////////////////////////////////////////////
    chk_state_t       state;
    chk_state_t       next_state;
    logic [SIG_W-1:0] lfsr;
    logic [SIG_W-1:0] next_lfsr;
    logic [LEN_W-1:0] count;
    logic [LEN_W-1:0] next_count;
    logic             next_block_done;
    logic             next_crc_error;
    logic             next_crc_irq;
    logic             take;
    logic             check_pulse;
    logic             cmp_mismatch;
    logic [SIG_W-1:0] folded;
    logic             last_word;
    logic             sig_bad;

    assign word_ready  = (state == ST_RUN);
    assign take        = word_valid && word_ready;
    assign folded      = crc_fold(lfsr, word_data, poly);
    assign last_word   = take && (count == LEN_W'(1));
    // a start in the same cycle aborts the block, so neither path judges it
    assign check_pulse = last_word && !start;
    assign sig_bad     = (folded != expect_sig);
    assign busy        = (state == ST_RUN);
    assign signature   = lfsr;

    always_comb begin
        next_state      = state;
        next_lfsr       = lfsr;
        next_count      = count;
        next_block_done = 1'b0;
        next_crc_error  = crc_error;
        next_crc_irq    = crc_irq;
        case (state)
            ST_IDLE, ST_DONE: begin
                if (prng_step) begin
                    next_lfsr = crc_fold(lfsr, '0, poly);
                end
            end
            ST_RUN: begin
                if (take) begin
                    next_lfsr  = folded;
                    next_count = count - LEN_W'(1);
                    if (last_word) begin
                        next_state      = ST_DONE;
                        next_block_done = 1'b1;
                        next_crc_error  = sig_bad;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (irq_clear) begin
            next_crc_irq = 1'b0;
        end
        // a mismatch in the clearing cycle must not be lost, so the set wins
        if (check_pulse && sig_bad) begin
            next_crc_irq = 1'b1;
        end
        if (start) begin
            // a zero length is treated as one word so the block always ends
            next_lfsr       = seed;
            next_count      = (block_len == '0) ? LEN_W'(1) : block_len;
            next_state      = ST_RUN;
            next_block_done = 1'b0;
            next_crc_error  = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            lfsr       <= SIG_RST;
            count      <= LEN_RST;
            block_done <= 1'b0;
            crc_error  <= 1'b0;
            crc_irq    <= 1'b0;
        end else if (clk_en) begin
            state      <= next_state;
            lfsr       <= next_lfsr;
            count      <= next_count;
            block_done <= next_block_done;
            crc_error  <= next_crc_error;
            crc_irq    <= next_crc_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sig_compare u_cmp (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .load_expect (start),
        .expect_in   (expect_sig),
        .check       (check_pulse),
        .sig_in      (folded),
        .mismatch    (cmp_mismatch)
    );

    ////////////////////////////////////////////////////////////////////////
    seed_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && start |=> lfsr == $past(seed) && busy)
        else $error("seed not loaded on start");
    fold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && take && !start |=> lfsr == crc_fold($past(lfsr), $past(word_data), $past(poly)))
        else $error("word not folded");
    count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && take && !start && count != LEN_W'(1) |=> count == $past(count) - LEN_W'(1) && busy)
        else $error("counter did not step");
    done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && check_pulse && !start |=> block_done && !busy)
        else $error("block end missed");
    irq_raise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && check_pulse && !start && crc_fold(lfsr, word_data, poly) != expect_sig |=> crc_irq)
        else $error("irq not raised on mismatch");
    redundant_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        block_done |-> cmp_mismatch == crc_error)
        else $error("compare paths disagree");
    prng_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && prng_step && !busy && !start |=> lfsr == crc_fold($past(lfsr), '0, $past(poly)))
        else $error("prng step wrong");
    poly_feed_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && take && !start && poly == '0
        |=> lfsr == {$past(lfsr[SIG_W-WORD_W-1:0]), WORD_W'(0)})
        else $error("polynomial not taken from its input");
    idle_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en |=> lfsr == $past(lfsr) && state == $past(state))
        else $error("state moved while frozen");
    irq_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && crc_irq && !irq_clear
        |=> crc_irq)
        else $error("irq dropped without clear");
    irq_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && irq_clear && !(check_pulse && sig_bad)
        |=> !crc_irq)
        else $error("irq not cleared");
    crc_result_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && check_pulse
        |=> crc_error == (lfsr != $past(expect_sig)))
        else $error("block result wrong");
    done_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && block_done
        |=> !block_done)
        else $error("block end held too long");
    zero_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && start && block_len == '0
        |=> count == LEN_W'(1) && busy)
        else $error("zero length not taken as one");
    count_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && start && block_len != '0
        |=> count == $past(block_len) && busy)
        else $error("block length not loaded");
    start_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && start
        |=> !crc_error && !block_done)
        else $error("old result kept over start");
    count_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && busy && !take && !start
        |=> count == $past(count) && busy)
        else $error("counter moved without a word");
    run_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && busy && !take && !start
        |=> lfsr == $past(lfsr))
        else $error("signature moved without a word");
    prng_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !busy && !prng_step && !start
        |=> lfsr == $past(lfsr))
        else $error("idle signature moved");
    frozen_flags_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en
        |=> crc_irq == $past(crc_irq) && crc_error == $past(crc_error) && count == $past(count))
        else $error("flags moved while frozen");
    cmp_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !check_pulse
        |=> cmp_mismatch == $past(cmp_mismatch))
        else $error("compare result moved between checks");
endmodule : memory_crc_checker

// ===== dv/word_source.sv
`timescale 1ns/100ps
// bus side that supplies memory words; holds each word until the block takes it
module word_source (
    input  wire logic        core_clk,
    input  wire logic        clk_en,
    input  wire logic        word_ready,
    output logic             word_valid,
    output logic [15:0]      word_data
);
    logic [15:0] q[$];
    initial begin
        word_valid = 1'h0;
        word_data  = 16'h0000;
    end
    always @(posedge core_clk) begin
        if (!word_valid || (word_ready && clk_en)) begin
            if (q.size() > 0) begin
                word_valid <= 1'h1;
                word_data  <= q.pop_front();
            end else begin
                word_valid <= 1'h0;
                // released bus must not keep showing the last word
                word_data  <= ~word_data;
            end
        end
    end
endmodule : word_source

// ===== dv/memory_crc_checker_tb.sv
`timescale 1ns/100ps
module memory_crc_checker_tb;
    import crc_check_pkg::*;
    logic              core_clk = 0, sys_rst = 1, clk_en = 1, start = 0, prng_step = 0, irq_clear = 0;
    logic [SIG_W-1:0]  poly = POLY_RST, seed = SIG_RST, expect_sig = EXPECT_RST, signature;
    logic [LEN_W-1:0]  block_len = LEN_RST;
    logic [WORD_W-1:0] word_data;
    logic              word_valid, word_ready, block_done, crc_error, crc_irq, busy;
    int                errors = 0, compares = 0;
    always #2.5 core_clk = ~core_clk;
    memory_crc_checker dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .poly(poly),
        .seed(seed), .block_len(block_len), .expect_sig(expect_sig), .start(start),
        .prng_step(prng_step), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data), .signature(signature), .block_done(block_done),
        .crc_error(crc_error), .crc_irq(crc_irq), .irq_clear(irq_clear), .busy(busy));
    word_source src (.core_clk(core_clk), .clk_en(clk_en), .word_ready(word_ready),
        .word_valid(word_valid), .word_data(word_data));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] fold(logic [31:0] s, logic [15:0] d, logic [31:0] p);
        for (int i = 15; i >= 0; i--) s = (s << 1) ^ ((s[31] ^ d[i]) ? p : 32'h0);
        return s;
    endfunction : fold
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    // words are queued before ready rises, so early words must be refused
    task automatic blk(logic [31:0] sd, logic [31:0] pl, logic ok, logic [15:0] w[$]);
        logic [31:0] s;
        s = sd;
        foreach (w[i]) s = fold(s, w[i], pl);
        @(posedge core_clk);
        seed <= sd;
        poly <= pl;
        block_len <= 16'(w.size());
        expect_sig <= ok ? s : ~s;
        start <= 1'h1;
        foreach (w[i]) src.q.push_back(w[i]);
        @(posedge core_clk);
        start <= 1'h0;
        for (int k = 0; k < 64 && block_done !== 1'h1; k++) @(negedge core_clk);
        chk("block_done", 32'h1, block_done);
        chk("signature", s, signature);
        chk("crc_error", ok ? 32'h0 : 32'h1, crc_error);
        chk("crc_irq", ok ? 32'h0 : 32'h1, crc_irq);
        chk("busy", 32'h0, busy);
        $display("test block done");
    endtask : blk
    task automatic t_clear;
        @(posedge core_clk);
        irq_clear <= 1'h1;
        @(posedge core_clk);
        irq_clear <= 1'h0;
        @(negedge core_clk);
        chk("crc_irq", 32'h0, crc_irq);
        chk("crc_error", 32'h1, crc_error);
        $display("test clear done");
    endtask : t_clear
    task automatic t_prng;
        logic [31:0] s;
        s = signature;
        for (int i = 0; i < 4; i++) s = fold(s, 16'h0000, poly);
        @(posedge core_clk);
        prng_step <= 1'h1;
        repeat (4) @(posedge core_clk);
        prng_step <= 1'h0;
        @(negedge core_clk);
        chk("signature", s, signature);
        $display("test prng done");
    endtask : t_prng
    task automatic t_reset;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'h0;
        @(negedge core_clk);
        chk("signature", SIG_RST, signature);
        chk("word_ready", 32'h0, word_ready);
        chk("busy", 32'h0, busy);
        chk("crc_irq", 32'h0, crc_irq);
        $display("test reset done");
    endtask : t_reset
    // a low clock enable must hold the LFSR even with a step request standing
    task automatic t_freeze;
        logic [31:0] s;
        s = signature;
        @(posedge core_clk);
        clk_en    <= 1'h0;
        prng_step <= 1'h1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("signature", s, signature);
        chk("crc_irq", 32'h0, crc_irq);
        @(posedge core_clk);
        clk_en    <= 1'h1;
        prng_step <= 1'h0;
        @(negedge core_clk);
        chk("signature", s, signature);
        $display("test freeze done");
    endtask : t_freeze
    // zero length runs one word; a step request during the stall is ignored
    task automatic t_zero_len;
        logic [31:0] s;
        s = fold(32'h0BAD_F00D, 16'h3C3C, POLY_RST);
        @(posedge core_clk);
        seed       <= 32'h0BAD_F00D;
        poly       <= POLY_RST;
        block_len  <= 16'h0000;
        expect_sig <= s;
        start      <= 1'h1;
        @(posedge core_clk);
        start     <= 1'h0;
        prng_step <= 1'h1;
        repeat (2) @(posedge core_clk);
        prng_step <= 1'h0;
        src.q.push_back(16'h3C3C);
        for (int k = 0; k < 64 && block_done !== 1'h1; k++) @(negedge core_clk);
        chk("block_done", 32'h1, block_done);
        chk("signature", s, signature);
        chk("crc_error", 32'h0, crc_error);
        chk("busy", 32'h0, busy);
        $display("test zero length done");
    endtask : t_zero_len
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        errors++;
        close_out();
    end
    initial begin
        t_reset();
        blk(32'h1234_5678, POLY_RST, 1'h1, '{16'hA5A5, 16'h0001, 16'hFFFF});
        blk(SIG_RST, 32'h1EDC_6F41, 1'h0, '{16'h8000});
        t_clear();
        t_prng();
        t_freeze();
        blk(32'h89AB_CDEF, 32'h0000_0000, 1'h1, '{16'h0F0F});
        t_zero_len();
        close_out();
    end
endmodule : memory_crc_checker_tb
